// ===== pkg/tap_pkg.sv
// Constants, codes and state types shared by the test port and its store
`default_nettype none
package tap_pkg;

    // ----------------------------------------------------------------
    // Register widths
    // ----------------------------------------------------------------
    localparam int IR_W = 8;
    localparam int ADDR_W = 10;
    localparam int COL_W = 89;
    localparam int SIG_W = 32;
    localparam int ID_W = 32;
    localparam int BYP_W = 1;

    typedef logic [IR_W-1:0] ir_t;

    // ----------------------------------------------------------------
    // Instruction codes
    // ----------------------------------------------------------------
    localparam ir_t INS_EXTEST = 8'h00;
    localparam ir_t INS_ADDR_SHIFT = 8'h01;
    localparam ir_t INS_DATA_SHIFT = 8'h02;
    localparam ir_t INS_BULK_ERASE = 8'h03;
    localparam ir_t INS_PROGRAM = 8'h07;
    localparam ir_t INS_PROG_SECURITY = 8'h09;
    localparam ir_t INS_VERIFY = 8'h0a;
    localparam ir_t INS_PROG_ENABLE = 8'h15;
    localparam ir_t INS_IDCODE = 8'h16;
    localparam ir_t INS_USERCODE = 8'h17;
    localparam ir_t INS_PROG_USERCODE = 8'h1a;
    localparam ir_t INS_PROG_DISABLE = 8'h1e;
    localparam ir_t INS_PROG_INCR = 8'h27;
    localparam ir_t INS_VERIFY_INCR = 8'h2a;
    localparam int IR_BYPASS_BIT = 7;

    // Identification value: arbitrary, names no real part
    localparam logic [ID_W-1:0] ID_VALUE = 32'h0a5c_3001;

    // ----------------------------------------------------------------
    // Store operations passed across the clock crossing
    // ----------------------------------------------------------------
    typedef logic [2:0] op_t;
    localparam op_t OP_PROGRAM = 3'h0;
    localparam op_t OP_ERASE = 3'h1;
    localparam op_t OP_VERIFY = 3'h2;
    localparam op_t OP_SIG = 3'h3;
    localparam op_t OP_SECURE = 3'h4;

    // ----------------------------------------------------------------
    // Controller states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [15:0] {
        S_RESET   = 16'h0001,
        S_IDLE    = 16'h0002,
        S_SEL_DR  = 16'h0004,
        S_CAP_DR  = 16'h0008,
        S_SH_DR   = 16'h0010,
        S_EX1_DR  = 16'h0020,
        S_PAU_DR  = 16'h0040,
        S_EX2_DR  = 16'h0080,
        S_UPD_DR  = 16'h0100,
        S_SEL_IR  = 16'h0200,
        S_CAP_IR  = 16'h0400,
        S_SH_IR   = 16'h0800,
        S_EX1_IR  = 16'h1000,
        S_PAU_IR  = 16'h2000,
        S_EX2_IR  = 16'h4000,
        S_UPD_IR  = 16'h8000
    } tap_state_t;

    typedef enum logic [1:0] {
        N_IDLE  = 2'h1,
        N_ERASE = 2'h2
    } nv_state_t;

endpackage
`default_nettype wire

// ===== logic/sync2.sv
// Two-flop synchroniser for a single level
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_q;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_q <= RST_VAL;
            q_o <= RST_VAL;
        end
        else
        begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== logic/nv_store.sv
// Non-volatile configuration store model on the system clock
`timescale 1ns/1ps
`default_nettype none
module nv_store
    import tap_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = COL_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_tgl_i,
    input wire op_t op_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] data_i,
    input wire logic [SIG_W-1:0] sig_i,
    output logic ack_tgl_o,
    output logic [DW-1:0] rd_o,
    output logic [SIG_W-1:0] sig_o,
    output logic secure_o,
    output logic busy_o
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic req_s;
    logic req_seen_q;
    logic [AW-1:0] wipe_q;
    logic start;
    logic wipe_last;
    nv_state_t st_q;

    sync2 u_req (.clk_i(clk_i), .rst_i(rst_i), .d_i(req_tgl_i), .q_o(req_s));

    assign start = (req_s != req_seen_q) && (st_q == N_IDLE);
    assign wipe_last = (wipe_q == {AW{1'b1}});

    // --------------------------------------------------------------
    // Operation sequencing
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q <= N_IDLE;
            req_seen_q <= 1'b0;
            ack_tgl_o <= 1'b0;
            wipe_q <= '0;
            busy_o <= 1'b0;
        end
        else
        begin
            case (st_q)
                N_IDLE:
                begin
                    if (start)
                    begin
                        req_seen_q <= req_s;
                        if (op_i == OP_ERASE)
                        begin
                            st_q <= N_ERASE;
                            wipe_q <= '0;
                            busy_o <= 1'b1;
                        end
                        else
                        begin
                            ack_tgl_o <= ~ack_tgl_o;
                        end
                    end
                end
                N_ERASE:
                begin
                    wipe_q <= wipe_q + 1'b1;
                    if (wipe_last)
                    begin
                        st_q <= N_IDLE;
                        busy_o <= 1'b0;
                        ack_tgl_o <= ~ack_tgl_o;
                    end
                end
                default:
                begin
                    st_q <= N_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // Cells: signature, security bit, column array
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sig_o <= '0;
            secure_o <= 1'b0;
            rd_o <= '0;
        end
        else if (st_q == N_ERASE)
        begin
            // Only a whole-device erase or the power-up reset lowers the security bit
            sig_o <= '0;
            secure_o <= 1'b0;
        end
        else if (start)
        begin
            if (op_i == OP_SIG)
                sig_o <= sig_i;
            if (op_i == OP_SECURE)
                secure_o <= 1'b1;
            if (op_i == OP_VERIFY)
                rd_o <= secure_o ? '0 : mem[addr_i];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (st_q == N_ERASE)
            mem[wipe_q] <= '0;
        else if (start && op_i == OP_PROGRAM)
            mem[addr_i] <= data_i;
    end
endmodule
`default_nettype wire

// ===== logic/tap_port.sv
// Test access port with programming control for the configuration store
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Sixteen-state controller stepped by clock and mode
// - Inputs sampled rising edge, output changes falling
// - Mode high reaches reset within five clocks
// - Controller starts in reset state at power-up
// - Six steady states; others last one clock
// - Idle does nothing unless operation pending
// - Scan branch starts with capture of selected path
// - Instruction capture loads identification instruction
// - Capture to shift or exit, then update/pause
// - Pause holds contents; exit2 resumes or updates
// - Store operations start on next idle entry
// - Other instructions take effect at update
// - Instruction selects data path and operation
// - Address, column data, then program writes cells
// - 32-bit user signature, writable and readable
// - Security bit blocks readout; only erase or power-up reset clears
// - Instruction register eight bits long
// - Top bit set selects one-bit bypass
// - Address register ten bits wide
// - Store operations need programming mode first
module tap_port
    import tap_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = COL_W,
    parameter logic [ID_W-1:0] ID_CODE = ID_VALUE
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic TCK_I,
    input wire logic TMS_I,
    input wire logic TDI_I,
    output logic TDO_O,
    output logic TDO_OE_O,
    output logic PROG_MODE_O,
    output logic NV_BUSY_O,
    output logic SECURED_O
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    tap_state_t st_q;
    tap_state_t st_d;
    logic trst;
    ir_t ir_sh_q;
    ir_t ir_q;
    logic [DW-1:0] dr_sh_q;
    logic [DW-1:0] dr_sh_d;
    logic [DW-1:0] cap_val;
    int dr_len;
    logic [AW-1:0] addr_q;
    logic [DW-1:0] col_q;
    logic [SIG_W-1:0] sig_wr_q;
    logic pend_q;
    op_t pend_op_q;
    logic incr_q;
    op_t op_q;
    logic req_tgl_q;
    logic ack_s;
    logic ack_seen_q;
    logic busy;
    logic ack_now;
    logic nv_ack;
    logic [DW-1:0] nv_rd;
    logic [SIG_W-1:0] nv_sig;
    logic is_nv_op;
    op_t new_op;
    logic new_incr;

    // ----------------------------------------------------------------
    // Reset for the link domain
    // ----------------------------------------------------------------
    // Power-up reset asserts at once and releases on the link clock; there
    // is no separate test reset pin, only this and the mode sequence.
    sync2 #(.RST_VAL(1'b1)) u_trst (
        .clk_i(TCK_I),
        .rst_i(RST_I),
        .d_i(1'b0),
        .q_o(trst)
    );

    // ----------------------------------------------------------------
    // Controller next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            S_RESET:  st_d = TMS_I ? S_RESET : S_IDLE;
            S_IDLE:   st_d = TMS_I ? S_SEL_DR : S_IDLE;
            S_SEL_DR: st_d = TMS_I ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: st_d = TMS_I ? S_EX1_DR : S_SH_DR;
            S_SH_DR:  st_d = TMS_I ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: st_d = TMS_I ? S_UPD_DR : S_PAU_DR;
            S_PAU_DR: st_d = TMS_I ? S_EX2_DR : S_PAU_DR;
            S_EX2_DR: st_d = TMS_I ? S_UPD_DR : S_SH_DR;
            S_UPD_DR: st_d = TMS_I ? S_SEL_DR : S_IDLE;
            S_SEL_IR: st_d = TMS_I ? S_RESET : S_CAP_IR;
            S_CAP_IR: st_d = TMS_I ? S_EX1_IR : S_SH_IR;
            S_SH_IR:  st_d = TMS_I ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: st_d = TMS_I ? S_UPD_IR : S_PAU_IR;
            S_PAU_IR: st_d = TMS_I ? S_EX2_IR : S_PAU_IR;
            S_EX2_IR: st_d = TMS_I ? S_UPD_IR : S_SH_IR;
            S_UPD_IR: st_d = TMS_I ? S_SEL_DR : S_IDLE;
            default:  st_d = S_RESET;
        endcase
    end

    always_ff @(posedge TCK_I or posedge trst)
    begin
        if (trst)
            st_q <= S_RESET;
        else
            st_q <= st_d;
    end

    // ----------------------------------------------------------------
    // Instruction register
    // ----------------------------------------------------------------
    always_ff @(posedge TCK_I or posedge trst)
    begin
        if (trst)
        begin
            ir_sh_q <= INS_IDCODE;
            ir_q <= INS_IDCODE;
        end
        else if (st_q == S_RESET)
        begin
            ir_q <= INS_IDCODE;
        end
        else if (st_q == S_CAP_IR)
        begin
            ir_sh_q <= INS_IDCODE;
        end
        else if (st_q == S_SH_IR)
        begin
            ir_sh_q <= {TDI_I, ir_sh_q[IR_W-1:1]};
        end
        else if (st_q == S_UPD_IR)
        begin
            ir_q <= ir_sh_q;
        end
    end

    always_ff @(posedge TCK_I or posedge trst)
    begin
        if (trst)
            PROG_MODE_O <= 1'b0;
        else if (st_q == S_RESET)
            PROG_MODE_O <= 1'b0;
        else if (st_q == S_UPD_IR && ir_sh_q == INS_PROG_ENABLE)
            PROG_MODE_O <= 1'b1;
        else if (st_q == S_UPD_IR && ir_sh_q == INS_PROG_DISABLE)
            PROG_MODE_O <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Data path selection
    // ----------------------------------------------------------------
    always_comb
    begin
        dr_len = BYP_W;
        cap_val = '0;
        if (ir_q[IR_BYPASS_BIT])
        begin
            dr_len = BYP_W;
            cap_val = '0;
        end
        else if (ir_q == INS_IDCODE)
        begin
            dr_len = ID_W;
            cap_val = {{(DW-ID_W){1'b0}}, ID_CODE};
        end
        else if (ir_q == INS_ADDR_SHIFT)
        begin
            dr_len = AW;
            cap_val = {{(DW-AW){1'b0}}, addr_q};
        end
        else if (ir_q == INS_DATA_SHIFT)
        begin
            dr_len = DW;
            cap_val = col_q;
        end
        else if (ir_q == INS_USERCODE)
        begin
            dr_len = SIG_W;
            cap_val = {{(DW-SIG_W){1'b0}}, nv_sig};
        end
    end

    // New bits enter at the far end of the selected length so the
    // shortest path still presents its bit 0 on the output.
    always_comb
    begin
        dr_sh_d = dr_sh_q;
        for (int i = 0; i < DW; i++)
        begin
            if (i == dr_len - 1)
                dr_sh_d[i] = TDI_I;
            else if (i < DW - 1)
                dr_sh_d[i] = dr_sh_q[i+1];
            else
                dr_sh_d[i] = 1'b0;
        end
    end

    always_ff @(posedge TCK_I or posedge trst)
    begin
        if (trst)
            dr_sh_q <= '0;
        else if (st_q == S_CAP_DR)
            dr_sh_q <= cap_val;
        else if (st_q == S_SH_DR)
            dr_sh_q <= dr_sh_d;
    end

    // ----------------------------------------------------------------
    // Address, column and signature staging
    // ----------------------------------------------------------------
    // Host writes are refused while the store is busy, since these
    // registers are the payload that the store reads across the crossing.
    always_ff @(posedge TCK_I or posedge trst)
    begin
        if (trst)
        begin
            addr_q <= '0;
            col_q <= '0;
            sig_wr_q <= '0;
        end
        else if (ack_now)
        begin
            if (op_q == OP_VERIFY)
                col_q <= nv_rd;
            if (incr_q)
                addr_q <= addr_q + 1'b1;
        end
        else if (st_q == S_UPD_DR && !busy)
        begin
            if (ir_q == INS_ADDR_SHIFT)
                addr_q <= dr_sh_q[AW-1:0];
            if (ir_q == INS_DATA_SHIFT)
                col_q <= dr_sh_q;
            if (ir_q == INS_USERCODE)
                sig_wr_q <= dr_sh_q[SIG_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Store operation launch
    // ----------------------------------------------------------------
    always_comb
    begin
        is_nv_op = 1'b1;
        new_op = OP_PROGRAM;
        new_incr = 1'b0;
        case (ir_sh_q)
            INS_PROGRAM:       new_op = OP_PROGRAM;
            INS_PROG_INCR:
            begin
                new_op = OP_PROGRAM;
                new_incr = 1'b1;
            end
            INS_BULK_ERASE:    new_op = OP_ERASE;
            INS_VERIFY:        new_op = OP_VERIFY;
            INS_VERIFY_INCR:
            begin
                new_op = OP_VERIFY;
                new_incr = 1'b1;
            end
            INS_PROG_USERCODE: new_op = OP_SIG;
            INS_PROG_SECURITY: new_op = OP_SECURE;
            default:           is_nv_op = 1'b0;
        endcase
    end

    assign busy = (req_tgl_q != ack_seen_q);
    assign ack_now = (ack_s != ack_seen_q);

    always_ff @(posedge TCK_I or posedge trst)
    begin
        if (trst)
        begin
            pend_q <= 1'b0;
            pend_op_q <= OP_PROGRAM;
            incr_q <= 1'b0;
            op_q <= OP_PROGRAM;
            req_tgl_q <= 1'b0;
        end
        else if (st_q == S_RESET)
        begin
            pend_q <= 1'b0;
        end
        else if (st_q == S_UPD_IR)
        begin
            // Without programming mode the operation is dropped
            pend_q <= is_nv_op && PROG_MODE_O;
            pend_op_q <= new_op;
            incr_q <= new_incr;
        end
        else if (st_q == S_IDLE && pend_q && !busy)
        begin
            op_q <= pend_op_q;
            req_tgl_q <= ~req_tgl_q;
            pend_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Completion back from the store
    // ----------------------------------------------------------------
    sync2 u_ack (.clk_i(TCK_I), .rst_i(trst), .d_i(nv_ack), .q_o(ack_s));

    always_ff @(posedge TCK_I or posedge trst)
    begin
        if (trst)
            ack_seen_q <= 1'b0;
        else
            ack_seen_q <= ack_s;
    end

    // ----------------------------------------------------------------
    // Serial output on the falling edge
    // ----------------------------------------------------------------
    always_ff @(negedge TCK_I or posedge trst)
    begin
        if (trst)
        begin
            TDO_O <= 1'b0;
            TDO_OE_O <= 1'b0;
        end
        else
        begin
            TDO_OE_O <= (st_q == S_SH_DR) || (st_q == S_SH_IR);
            if (st_q == S_SH_IR)
                TDO_O <= ir_sh_q[0];
            else if (st_q == S_SH_DR)
                TDO_O <= dr_sh_q[0];
            else
                TDO_O <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Configuration store
    // ----------------------------------------------------------------
    nv_store #(.AW(AW), .DW(DW)) u_store (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .req_tgl_i(req_tgl_q),
        .op_i(op_q),
        .addr_i(addr_q),
        .data_i(col_q),
        .sig_i(sig_wr_q),
        .ack_tgl_o(nv_ack),
        .rd_o(nv_rd),
        .sig_o(nv_sig),
        .secure_o(SECURED_O),
        .busy_o(NV_BUSY_O)
    );
endmodule
`default_nettype wire

// ===== tb/jtag_host.sv
// Behavioural host on the far side of the test port
`timescale 1ns/1ps
`default_nettype none
module jtag_host (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i,
    input wire logic tdo_oe_i
);
    // Link clock stands low outside frames
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    // One link clock; inputs move only while the clock is low
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #24;
        tck_o = 1'b1;
        tdo = tdo_oe_i ? tdo_i : 1'bx;
        #24;
        tck_o = 1'b0;
    endtask

    // Data line toggles when it carries nothing
    task automatic nav(input logic tms);
        logic d;
        step(tms, ~tdi_o, d);
    endtask

    // Idle to idle scan, least significant bit first
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
            output logic [127:0] dout);
        logic b;
        dout = '0;
        nav(1'b1);
        if (ir)
            nav(1'b1);
        nav(1'b0);
        nav(1'b0);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        nav(1'b1);
        nav(1'b0);
    endtask
endmodule
`default_nettype wire

// ===== tb/tap_port_assertions.sv
// Concurrent checks on the test port pins
`timescale 1ns/1ps
`default_nettype none
module tap_port_assertions #(
    parameter int AW = 10
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic TCK_I,
    input wire logic TMS_I,
    input wire logic TDI_I,
    input wire logic TDO_O,
    input wire logic TDO_OE_O,
    input wire logic PROG_MODE_O,
    input wire logic NV_BUSY_O,
    input wire logic SECURED_O
);
    localparam int ERASE_N = 2 ** AW;
    logic [1:0] out_rise_q;
    logic [31:0] busy_cnt_q;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    always_ff @(posedge TCK_I or posedge RST_I)
    begin
        if (RST_I)
            out_rise_q <= 2'h0;
        else
            out_rise_q <= {TDO_OE_O, TDO_O};
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            busy_cnt_q <= 32'h0;
        else if (NV_BUSY_O)
            busy_cnt_q <= busy_cnt_q + 32'h1;
        else
            busy_cnt_q <= 32'h0;
    end

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_fall_only;
        @(negedge TCK_I) disable iff (RST_I) {TDO_OE_O, TDO_O} == out_rise_q;
    endproperty
    a_fall_only: assert property (p_fall_only)
        else $error("serial out moved on rising edge");

    property p_tms_reset;
        @(posedge TCK_I) disable iff (RST_I) TMS_I [*5] |=> !TDO_OE_O;
    endproperty
    a_tms_reset: assert property (p_tms_reset)
        else $error("not in reset after mode held high");

    property p_mode_clear;
        @(posedge TCK_I) disable iff (RST_I) TMS_I [*6] |=> !PROG_MODE_O;
    endproperty
    a_mode_clear: assert property (p_mode_clear)
        else $error("programming mode kept through reset");

    property p_release;
        @(posedge CLK_I) disable iff (RST_I)
            $fell(RST_I) |-> !TDO_OE_O && !PROG_MODE_O && !SECURED_O;
    endproperty
    a_release: assert property (p_release)
        else $error("outputs not cleared by power-up reset");

    property p_shift_entry;
        @(posedge TCK_I) disable iff (RST_I)
            $rose(TDO_OE_O) |-> !$past(TMS_I) && ($past(TMS_I, 2) != $past(TMS_I, 3));
    endproperty
    a_shift_entry: assert property (p_shift_entry)
        else $error("shift entered without capture");

    property p_shift_hold;
        @(posedge TCK_I) disable iff (RST_I) TDO_OE_O |=> TDO_OE_O == !$past(TMS_I);
    endproperty
    a_shift_hold: assert property (p_shift_hold)
        else $error("shift state not steady or exit missed");

    property p_quiet;
        @(posedge TCK_I) disable iff (RST_I) !TDO_OE_O |-> !TDO_O;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("serial out active outside shift");

    property p_erase_mode;
        @(posedge CLK_I) disable iff (RST_I)
            $rose(NV_BUSY_O) || $rose(SECURED_O) |-> PROG_MODE_O;
    endproperty
    a_erase_mode: assert property (p_erase_mode)
        else $error("store operation outside programming mode");

    property p_secure_clear;
        @(posedge CLK_I) disable iff (RST_I)
            $fell(SECURED_O) |-> NV_BUSY_O || $past(NV_BUSY_O) || $past(NV_BUSY_O, 2);
    endproperty
    a_secure_clear: assert property (p_secure_clear)
        else $error("security bit cleared without erase");

    property p_erase_len;
        @(posedge CLK_I) disable iff (RST_I)
            $fell(NV_BUSY_O) |-> busy_cnt_q inside {[ERASE_N - 1:ERASE_N + 1]};
    endproperty
    a_erase_len: assert property (p_erase_len)
        else $error("erase length wrong");

    c_erase: cover property (@(posedge CLK_I) $fell(NV_BUSY_O));
    c_secure: cover property (@(posedge CLK_I) $rose(SECURED_O));
    c_shift: cover property (@(posedge TCK_I) $rose(TDO_OE_O));
endmodule
`default_nettype wire

// ===== tb/tap_port_tb.sv
// Self-checking bench for the test port
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) \
    begin \
        tests_run++; \
        if ((act) !== (exp)) \
        begin \
            fail_count++; \
            $display("mismatch at %0t: got %h want %h", $time, act, exp); \
        end \
    end

module tap_port_tb;
    import tap_pkg::*;
    logic clk, rst, tck, tms, tdi, tdo, tdo_oe, prog_mode, nv_busy, secured;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [127:0] q;
    localparam logic [31:0] SIG = 32'hc3a5_5a3c;
    localparam logic [9:0] ADR = 10'h2d5;
    localparam logic [88:0] COL = {25'h1a5_5a5a, 64'hf00d_1234_5678_9abc};

    tap_port DUT (.CLK_I(clk), .RST_I(rst), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
        .TDO_O(tdo), .TDO_OE_O(tdo_oe), .PROG_MODE_O(prog_mode),
        .NV_BUSY_O(nv_busy), .SECURED_O(secured));
    jtag_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic end_sim();
        if (fail_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic ir(input ir_t c);
        logic [127:0] r;
        host.scan(1'b1, IR_W, {120'h0, c}, r);
        `CHK(r[7:0], INS_IDCODE);
    endtask

    task automatic dr(input int n, input logic [127:0] d);
        host.scan(1'b0, n, d, q);
    endtask

    task automatic idle(input int n);
        repeat (n) host.nav(1'b0);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_ident();
        dr(ID_W, 128'h0);
        `CHK(q[31:0], ID_VALUE);
    endtask
    task automatic t_bypass();
        ir_t codes [3] = '{8'h80, 8'hff, INS_EXTEST};
        foreach (codes[i])
        begin
            ir(codes[i]);
            dr(4, 128'hb);
            `CHK(q[3:0], 4'h6);
        end
    endtask

    task automatic t_pause();
        logic b;
        ir(INS_IDCODE);
        q = '0;
        host.nav(1'b1);
        host.nav(1'b0);
        host.nav(1'b0);
        for (int i = 0; i < 32; i++)
        begin
            host.step(i == 15 || i == 31, 1'b0, b);
            q[i] = b;
            if (i == 15)
            begin
                idle(3);
                host.nav(1'b1);
                host.nav(1'b0);
            end
        end
        host.nav(1'b1);
        host.nav(1'b0);
        `CHK(q[31:0], ID_VALUE);
    endtask

    task automatic t_tms_reset();
        ir(8'hff);
        repeat (5) host.nav(1'b1);
        idle(1);
        dr(ID_W, 128'h0);
        `CHK(q[31:0], ID_VALUE);
    endtask

    task automatic t_prog();
        ir(INS_USERCODE);
        dr(SIG_W, SIG);
        ir(INS_PROG_USERCODE);
        idle(6);
        ir(INS_USERCODE);
        dr(SIG_W, 128'h0);
        `CHK(q[31:0], 32'h0);
        ir(INS_PROG_ENABLE);
        `CHK(prog_mode, 1'b1);
        ir(INS_USERCODE);
        dr(SIG_W, SIG);
        ir(INS_PROG_USERCODE);
        idle(6);
        ir(INS_USERCODE);
        dr(SIG_W, 128'h0);
        `CHK(q[31:0], SIG);
        ir(INS_ADDR_SHIFT);
        dr(ADDR_W, ADR);
        ir(INS_DATA_SHIFT);
        dr(COL_W, COL);
        ir(INS_PROGRAM);
        idle(6);
        ir(INS_DATA_SHIFT);
        dr(COL_W, 128'h0);
        ir(INS_VERIFY_INCR);
        idle(6);
        ir(INS_DATA_SHIFT);
        dr(COL_W, COL);
        `CHK(q[88:0], COL);
        ir(INS_PROG_INCR);
        idle(6);
        ir(INS_ADDR_SHIFT);
        dr(ADDR_W, ADR);
        `CHK(q[9:0], ADR + 10'h2);
    endtask

    task automatic t_secure();
        ir(INS_PROG_SECURITY);
        idle(6);
        `CHK(secured, 1'b1);
        ir(INS_VERIFY);
        idle(6);
        ir(INS_DATA_SHIFT);
        dr(COL_W, 128'h0);
        `CHK(q[88:0], 89'h0);
        ir(INS_BULK_ERASE);
        idle(2);
        for (int k = 0; k < 50 && !nv_busy; k++)
            @(negedge clk);
        `CHK(nv_busy, 1'b1);
        for (int k = 0; k < 1100 && nv_busy; k++)
            @(negedge clk);
        `CHK({nv_busy, secured}, 2'b00);
        ir(INS_PROG_DISABLE);
        `CHK(prog_mode, 1'b0);
        ir(INS_PROG_ENABLE);
        repeat (6) host.nav(1'b1);
        idle(1);
        `CHK(prog_mode, 1'b0);
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fail_count++;
            end_sim();
        end
    end

    initial
    begin
        rst = 1'b1;
        host.nav(1'b1);
        @(negedge clk);
        rst = 1'b0;
        repeat (5) host.nav(1'b1);
        idle(1);
        t_ident();
        t_bypass();
        t_pause();
        t_tms_reset();
        t_prog();
        t_secure();
        end_sim();
    end
endmodule

bind tap_port tap_port_assertions #(.AW(AW)) chk (.CLK_I, .RST_I, .TCK_I, .TMS_I, .TDI_I,
    .TDO_O, .TDO_OE_O, .PROG_MODE_O, .NV_BUSY_O, .SECURED_O);
`default_nettype wire
